// ---- rtl/acr_pkg.sv ----
package acr_pkg;
	// ****************************************************************
	// setup word layout
	// ****************************************************************
	localparam int CFG_W = 24;
	localparam int CMD_W = 8;
	localparam int FRAME_W = CMD_W + CFG_W;
	localparam int LATCH_HI = 23;
	localparam int LATCH_LO = 20;
	localparam int CHOP_BIT = 18;
	localparam int LOWP_BIT = 16;
	localparam int RATE_HI = 15;
	localparam int RATE_LO = 13;
	localparam int POL_BIT = 12;
	localparam int RANGE_HI = 11;
	localparam int RANGE_LO = 9;
	localparam int PUMP_BIT = 8;
	localparam int RST_BIT = 7;
	localparam int SEEN_BIT = 6;
	localparam int PFLAG_BIT = 5;
	localparam int SLEEP_BIT = 4;
	localparam int DONE_BIT = 3;
	localparam int CAL_HI = 2;
	localparam int CAL_LO = 0;
	localparam logic [CFG_W-1:0] CFG_RESET = 24'h000040;
	// bits the host may change: no unused, seen or done bits
	localparam logic [CFG_W-1:0] CFG_WMASK = 24'hF5FFB7;
	localparam logic [CFG_W-1:0] CFG_UNUSED = 24'h0A0000;
	// ****************************************************************
	// command word
	// ****************************************************************
	localparam logic [CMD_W-1:0] CMD_WR_CFG = 8'h84;
	localparam logic [CMD_W-1:0] CMD_RD_CFG = 8'h94;
	localparam logic [CMD_W-1:0] CMD_FIXED_MASK = 8'hEF;
	// ****************************************************************
	// oscillator derived timing
	// ****************************************************************
	localparam int OSC_HZ = 32768;
	localparam int CHOP_SLOW_HZ = 256;
	localparam int CHOP_FAST_HZ = 32768;
	localparam int CHOP_SLOW_DIV = OSC_HZ / CHOP_SLOW_HZ;
	localparam int CHOP_FAST_DIV = OSC_HZ / CHOP_FAST_HZ;
	localparam int PERIOD_W = 14;
	localparam logic [2:0] RANGE_BAD0 = 3'h6;
	localparam logic [2:0] RANGE_BAD1 = 3'h7;
	localparam logic [2:0] CAL_BAD0 = 3'h4;
	localparam logic [2:0] CAL_BAD1 = 3'h7;
	// ****************************************************************
	// host register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_WDATA = 8'h04;
	localparam logic [7:0] HOST_RDATA = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0C;
	localparam logic [7:0] HOST_IRQ_STAT = 8'h10;
	localparam logic [7:0] HOST_IRQ_CLR = 8'h14;
	localparam logic [7:0] HOST_IRQ_EN = 8'h18;
	localparam int CTRL_START = 0;
	localparam int CTRL_READ = 1;
	localparam int IRQ_XFER = 0;
	localparam int IRQ_REFUSE = 1;
	localparam int SCLK_HALF = 8;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_LOW = 2'b01,
		HS_HIGH = 2'b10
	} acr_host_state_t;

	// conversion period in oscillator cycles per word-rate code
	function automatic logic [PERIOD_W-1:0] acr_word_period(input logic [2:0] code);
		case (code)
			3'h0: acr_word_period = 14'h0886;
			3'h1: acr_word_period = 14'h0442;
			3'h2: acr_word_period = 14'h0222;
			3'h3: acr_word_period = 14'h010A;
			3'h4: acr_word_period = 14'h00C2;
			3'h5: acr_word_period = 14'h00A2;
			3'h6: acr_word_period = 14'h2212;
			default: acr_word_period = 14'h110A;
		endcase
	endfunction : acr_word_period
endpackage : acr_pkg

// ---- rtl/acr_link_if.sv ----
interface acr_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	modport dev(input sclk, input cs_n, input sdi, output sdo);
	modport host(output sclk, output cs_n, output sdi, input sdo);
endinterface : acr_link_if

// ---- rtl/acr_device.sv ----
// What this block does
// - latch pins follow top four setup bits
// - host writes zero to unused bits
// - chop select: 256 Hz or 32768 Hz
// - low-power bit selects reduced power mode
// - word-rate field sets conversion period
// - polarity bit: bipolar clear, unipolar set
// - range field selects input range; codes 110/111 unused
// - pump-off bit floats pump drive pin
// - reset bit starts reset; host clears later
// - reset-seen flag read-only, cleared by read
// - port flag mode bit enables flag mode
// - sleep depth: standby or oscillator-off sleep
// - done flag set on cycle completion
// - calibration field selects cal type
// - reset clears latch bits and pins
// - seen flag holds until unreset and read
// - 24 clocks after valid command shift data
module acr_device (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// serial port
	acr_link_if.dev link,
	// converter oscillator
	input wire logic osc_input_clock,
	// setup outputs
	output logic [3:0] latch_out_bits,
	output logic chop_rate_select,
	output logic chop_tick,
	output logic low_power_select,
	output logic [2:0] word_rate_field,
	output logic unipolar_select,
	output logic [2:0] input_range_field,
	output logic pump_drive_pin,
	output logic pump_drive_oe,
	output logic system_reset_trigger,
	output logic port_flag_mode,
	output logic sleep_depth_select,
	output logic cycle_done_flag,
	output logic [2:0] calibration_select
);
	// ****************************************************************
	// synchronisers
	// ****************************************************************
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic cs_s1_q, cs_s2_q;
	logic sdi_s1_q, sdi_s2_q;
	logic osc_s1_q, osc_s2_q, osc_s3_q;
	logic sclk_rise, sclk_fall, in_frame, osc_rise;

	// two flops on every pin, a third only for edge finding
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			sclk_s1_q <= link.sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_s1_q <= link.cs_n;
			cs_s2_q <= cs_s1_q;
			sdi_s1_q <= link.sdi;
			sdi_s2_q <= sdi_s1_q;
			osc_s1_q <= osc_input_clock;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// edges of the synchronised clocks
	assign in_frame = ~cs_s2_q;
	assign sclk_rise = in_frame & sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall = in_frame & ~sclk_s2_q & sclk_s3_q;
	assign osc_rise = osc_s2_q & ~osc_s3_q;

	// ****************************************************************
	// serial frame
	// ****************************************************************
	logic [5:0] bit_cnt_q;
	logic [acr_pkg::CMD_W-1:0] cmd_q;
	logic [acr_pkg::CFG_W-1:0] wr_sh_q, rd_sh_q, cfg_q;
	logic sel_ok_q, is_read_q, sdo_q;
	logic [acr_pkg::CMD_W-1:0] cmd_full;
	logic [acr_pkg::CFG_W-1:0] wr_full;
	logic cmd_end, word_end, write_commit, read_done;

	assign cmd_full = {cmd_q[acr_pkg::CMD_W-2:0], sdi_s2_q};
	assign wr_full = {wr_sh_q[acr_pkg::CFG_W-2:0], sdi_s2_q};
	assign cmd_end = sclk_rise & (bit_cnt_q == 6'(acr_pkg::CMD_W - 1));
	assign word_end = sclk_rise & sel_ok_q & (bit_cnt_q == 6'(acr_pkg::FRAME_W - 1));
	assign write_commit = word_end & ~is_read_q;
	assign read_done = word_end & is_read_q;

	// bit counter, cleared whenever chip select is high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt_q <= 6'h00;
		end else if (!in_frame) begin
			bit_cnt_q <= 6'h00;
		end else if (sclk_rise && bit_cnt_q != 6'(acr_pkg::FRAME_W)) begin
			bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	// command and write data shift in, first bit is the top bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 8'h00;
			wr_sh_q <= 24'h000000;
		end else if (sclk_rise) begin
			if (bit_cnt_q < 6'(acr_pkg::CMD_W)) begin
				cmd_q <= cmd_full;
			end else begin
				wr_sh_q <= wr_full;
			end
		end
	end

	// decode the command; other commands leave the frame ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ok_q <= 1'b0;
			is_read_q <= 1'b0;
		end else if (!in_frame) begin
			sel_ok_q <= 1'b0;
		end else if (cmd_end) begin
			sel_ok_q <= (cmd_full & acr_pkg::CMD_FIXED_MASK) == acr_pkg::CMD_WR_CFG;
			is_read_q <= cmd_full == acr_pkg::CMD_RD_CFG;
		end
	end

	// read data leaves on falling edges, top bit first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_sh_q <= 24'h000000;
			sdo_q <= 1'b0;
		end else if (!in_frame) begin
			sdo_q <= 1'b0;
		end else if (cmd_end) begin
			rd_sh_q <= cfg_q;
		end else if (sclk_fall && sel_ok_q && is_read_q && bit_cnt_q >= 6'(acr_pkg::CMD_W)) begin
			sdo_q <= rd_sh_q[acr_pkg::CFG_W-1];
			rd_sh_q <= {rd_sh_q[acr_pkg::CFG_W-2:0], 1'b0};
		end
	end

	assign link.sdo = sdo_q;

	// ****************************************************************
	// conversion timing on the oscillator
	// ****************************************************************
	logic [acr_pkg::PERIOD_W-1:0] conv_cnt_q, period;
	logic conv_end;
	logic [7:0] chop_cnt_q;
	logic chop_tick_q, pump_q, pump_oe_q;

	assign period = acr_pkg::acr_word_period(cfg_q[acr_pkg::RATE_HI:acr_pkg::RATE_LO]);
	assign conv_end = osc_rise & ~cfg_q[acr_pkg::RST_BIT] & (conv_cnt_q == period - 14'h0001);

	// conversion (or calibration) cycle counter, held during reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_cnt_q <= 14'h0000;
		end else if (write_commit || cfg_q[acr_pkg::RST_BIT] || conv_end) begin
			conv_cnt_q <= 14'h0000;
		end else if (osc_rise) begin
			conv_cnt_q <= conv_cnt_q + 14'h0001;
		end
	end

	// amplifier chop tick: every osc edge fast, every 128th slow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chop_cnt_q <= 8'h00;
			chop_tick_q <= 1'b0;
		end else begin
			chop_tick_q <= 1'b0;
			if (osc_rise) begin
				if (cfg_q[acr_pkg::CHOP_BIT] || chop_cnt_q == 8'(acr_pkg::CHOP_SLOW_DIV - 1)) begin
					chop_cnt_q <= 8'h00;
					chop_tick_q <= 1'b1;
				end else begin
					chop_cnt_q <= chop_cnt_q + 8'h01;
				end
			end
		end
	end

	// charge pump drive toggles with the oscillator, floats when off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pump_q <= 1'b0;
			pump_oe_q <= 1'b1;
		end else begin
			pump_oe_q <= ~cfg_q[acr_pkg::PUMP_BIT];
			if (cfg_q[acr_pkg::PUMP_BIT]) begin
				pump_q <= 1'b0;
			end else if (osc_rise) begin
				pump_q <= ~pump_q;
			end
		end
	end

	// ****************************************************************
	// setup register
	// ****************************************************************
	logic [acr_pkg::CFG_W-1:0] merged;
	assign merged = (wr_full & acr_pkg::CFG_WMASK) | (cfg_q & ~acr_pkg::CFG_WMASK);

	// writes, reset cycle, seen flag and done flag; a set beats a read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= acr_pkg::CFG_RESET;
		end else if (write_commit && wr_full[acr_pkg::RST_BIT]) begin
			cfg_q <= acr_pkg::CFG_RESET | (24'h000001 << acr_pkg::RST_BIT);
		end else if (write_commit) begin
			cfg_q <= merged;
			// a cycle end in the same clock still marks done
			if (conv_end) begin
				cfg_q[acr_pkg::DONE_BIT] <= 1'b1;
			end
		end else begin
			if (read_done && !cfg_q[acr_pkg::RST_BIT]) begin
				cfg_q[acr_pkg::SEEN_BIT] <= 1'b0;
			end
			if (conv_end) begin
				cfg_q[acr_pkg::DONE_BIT] <= 1'b1;
			end else if (read_done) begin
				cfg_q[acr_pkg::DONE_BIT] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign latch_out_bits = cfg_q[acr_pkg::LATCH_HI:acr_pkg::LATCH_LO];
	assign chop_rate_select = cfg_q[acr_pkg::CHOP_BIT];
	assign chop_tick = chop_tick_q;
	assign low_power_select = cfg_q[acr_pkg::LOWP_BIT];
	assign word_rate_field = cfg_q[acr_pkg::RATE_HI:acr_pkg::RATE_LO];
	assign unipolar_select = cfg_q[acr_pkg::POL_BIT];
	assign input_range_field = cfg_q[acr_pkg::RANGE_HI:acr_pkg::RANGE_LO];
	assign pump_drive_pin = pump_q;
	assign pump_drive_oe = pump_oe_q;
	assign system_reset_trigger = cfg_q[acr_pkg::RST_BIT];
	assign port_flag_mode = cfg_q[acr_pkg::PFLAG_BIT];
	assign sleep_depth_select = cfg_q[acr_pkg::SLEEP_BIT];
	assign cycle_done_flag = cfg_q[acr_pkg::DONE_BIT];
	assign calibration_select = cfg_q[acr_pkg::CAL_HI:acr_pkg::CAL_LO];
endmodule : acr_device

// ---- rtl/acr_host.sv ----
module acr_host #(
	parameter int SCLK_HALF = acr_pkg::SCLK_HALF
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq,
	// serial port
	acr_link_if.host link
);
	// ****************************************************************
	// bus slave, zero wait states
	// ****************************************************************
	logic dp_wr_q;
	logic [7:0] dp_addr_q;
	logic [31:0] hrdata_q;
	logic [23:0] wdata_q, rdata_q;
	logic [1:0] irq_stat_q, irq_en_q, irq_set;
	logic irq_q, busy;
	logic start_wr, ctrl_read;
	logic [7:0] rd_addr;

	assign rd_addr = haddr[7:0];

	// address phase capture and read data for the coming data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata_q <= 32'h00000000;
		end else if (hready) begin
			dp_wr_q <= hsel & htrans[1] & hwrite;
			dp_addr_q <= rd_addr;
			if (hsel && htrans[1] && !hwrite) begin
				case (rd_addr)
					acr_pkg::HOST_WDATA: hrdata_q <= {8'h00, wdata_q};
					acr_pkg::HOST_RDATA: hrdata_q <= {8'h00, rdata_q};
					acr_pkg::HOST_STATUS: hrdata_q <= {31'h00000000, busy};
					acr_pkg::HOST_IRQ_STAT: hrdata_q <= {30'h00000000, irq_stat_q};
					acr_pkg::HOST_IRQ_EN: hrdata_q <= {30'h00000000, irq_en_q};
					default: hrdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign start_wr = dp_wr_q & (dp_addr_q == acr_pkg::HOST_CTRL) & hwdata[acr_pkg::CTRL_START];
	assign ctrl_read = hwdata[acr_pkg::CTRL_READ];

	// software registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdata_q <= 24'h000000;
			irq_en_q <= 2'h0;
		end else if (dp_wr_q) begin
			if (dp_addr_q == acr_pkg::HOST_WDATA) begin
				wdata_q <= hwdata[23:0];
			end
			if (dp_addr_q == acr_pkg::HOST_IRQ_EN) begin
				irq_en_q <= hwdata[1:0];
			end
		end
	end

	// sticky events, set wins over write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			if (dp_wr_q && dp_addr_q == acr_pkg::HOST_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~hwdata[1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign irq = irq_q;

	// ****************************************************************
	// serial master
	// ****************************************************************
	acr_pkg::acr_host_state_t state_q;
	logic [15:0] half_cnt_q;
	logic [5:0] bits_q;
	logic [acr_pkg::FRAME_W-1:0] tx_q, rx_q;
	logic sclk_q, cs_n_q, sdo_s1_q, sdo_s2_q, half_end;
	logic [2:0] req_range, req_cal;
	logic bad_code, launch;

	assign req_range = wdata_q[acr_pkg::RANGE_HI:acr_pkg::RANGE_LO];
	assign req_cal = wdata_q[acr_pkg::CAL_HI:acr_pkg::CAL_LO];
	// forbidden range or calibration codes are never sent
	assign bad_code = ~ctrl_read & ((req_range == acr_pkg::RANGE_BAD0) | (req_range == acr_pkg::RANGE_BAD1)
		| (req_cal == acr_pkg::CAL_BAD0) | (req_cal == acr_pkg::CAL_BAD1));
	assign launch = start_wr & (state_q == acr_pkg::HS_IDLE) & ~bad_code;
	assign irq_set[acr_pkg::IRQ_REFUSE] = start_wr & (state_q == acr_pkg::HS_IDLE) & bad_code;
	assign irq_set[acr_pkg::IRQ_XFER] = (state_q == acr_pkg::HS_HIGH) & half_end
		& (bits_q == 6'(acr_pkg::FRAME_W - 1));
	assign half_end = half_cnt_q == 16'(SCLK_HALF - 1);
	assign busy = state_q != acr_pkg::HS_IDLE;

	// read data pin through two flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdo_s1_q <= 1'b0;
			sdo_s2_q <= 1'b0;
		end else begin
			sdo_s1_q <= link.sdo;
			sdo_s2_q <= sdo_s1_q;
		end
	end

	// frame: command byte then 24 data bits, top bit first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= acr_pkg::HS_IDLE;
			half_cnt_q <= 16'h0000;
			bits_q <= 6'h00;
			tx_q <= 32'h00000000;
			rx_q <= 32'h00000000;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			rdata_q <= 24'h000000;
		end else begin
			case (state_q)
				acr_pkg::HS_IDLE: begin
					if (launch) begin
						tx_q <= ctrl_read ? {acr_pkg::CMD_RD_CFG, 24'h000000}
							: {acr_pkg::CMD_WR_CFG, wdata_q & ~acr_pkg::CFG_UNUSED};
						cs_n_q <= 1'b0;
						half_cnt_q <= 16'h0000;
						bits_q <= 6'h00;
						state_q <= acr_pkg::HS_LOW;
					end
				end
				acr_pkg::HS_LOW: begin
					half_cnt_q <= half_end ? 16'h0000 : half_cnt_q + 16'h0001;
					if (half_end) begin
						sclk_q <= 1'b1;
						rx_q <= {rx_q[acr_pkg::FRAME_W-2:0], sdo_s2_q};
						state_q <= acr_pkg::HS_HIGH;
					end
				end
				acr_pkg::HS_HIGH: begin
					half_cnt_q <= half_end ? 16'h0000 : half_cnt_q + 16'h0001;
					if (half_end) begin
						sclk_q <= 1'b0;
						tx_q <= {tx_q[acr_pkg::FRAME_W-2:0], 1'b0};
						bits_q <= bits_q + 6'h01;
						if (bits_q == 6'(acr_pkg::FRAME_W - 1)) begin
							cs_n_q <= 1'b1;
							rdata_q <= rx_q[acr_pkg::CFG_W-1:0];
							state_q <= acr_pkg::HS_IDLE;
						end else begin
							state_q <= acr_pkg::HS_LOW;
						end
					end
				end
				default: state_q <= acr_pkg::HS_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.sdi = tx_q[acr_pkg::FRAME_W-1];
endmodule : acr_host

// ---- bench/acr_monitor.sv ----
module acr_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic sclk_q;
	logic [5:0] rises_q;
	// counts serial clock rises inside one frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 1'b0;
			rises_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n) begin
				rises_q <= 6'h00;
			end else if (sclk && !sclk_q) begin
				rises_q <= rises_q + 6'h01;
			end
		end
	end
	chk_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	chk_frame_pulse_count: assert property ($rose(cs_n) |-> rises_q == 6'h20)
		else $error("frame did not carry 32 clock pulses");
	chk_frame_length: assert property ($fell(cs_n) |-> ##[500:530] $rose(cs_n))
		else $error("frame length out of range");
	chk_lead_in_low: assert property ($fell(cs_n) |-> !sclk [*6])
		else $error("serial clock rose too soon after select");
	chk_high_width: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("serial clock high phase wrong width");
	chk_low_width: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("serial clock low phase too short");
	chk_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("host data changed while clock high");
	chk_sdo_hold: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdo))
		else $error("device data changed while clock high");
	chk_frame_gap: assert property ($rose(cs_n) |=> cs_n)
		else $error("frames not separated by an idle cycle");
endmodule : acr_monitor

// ---- bench/test_adc_configuration_register.sv ----
module test_adc_configuration_register;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, osc_input_clock, osc_en, sclk_q, pump_q;
	logic [1:0] htrans, osc_div;
	logic [2:0] hsize, word_rate_field, input_range_field, calibration_select;
	logic [3:0] latch_out_bits;
	logic chop_rate_select, chop_tick, low_power_select, unipolar_select, pump_drive_pin, pump_drive_oe;
	logic system_reset_trigger, port_flag_mode, sleep_depth_select, cycle_done_flag;
	logic [31:0] haddr, hwdata, hrdata, rd, sdi_sh, sdo_sh;
	logic [23:0] w;
	logic [2:0] cal_codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h0, 3'h1};
	logic [23:0] bad [4] = '{24'h000C00, 24'h000E00, 24'h000004, 24'h000007};
	int mismatches, n_checks, ticks, toggles;
	wire logic [23:0] outs = {latch_out_bits, 1'b0, chop_rate_select, 1'b0, low_power_select, word_rate_field,
		unipolar_select, input_range_field, ~pump_drive_oe, system_reset_trigger, 1'b0, port_flag_mode,
		sleep_depth_select, 1'b0, calibration_select};
	acr_link_if link ();
	acr_device acr_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link), .osc_input_clock(osc_input_clock),
		.latch_out_bits(latch_out_bits), .chop_rate_select(chop_rate_select), .chop_tick(chop_tick),
		.low_power_select(low_power_select), .word_rate_field(word_rate_field), .unipolar_select(unipolar_select),
		.input_range_field(input_range_field), .pump_drive_pin(pump_drive_pin), .pump_drive_oe(pump_drive_oe),
		.system_reset_trigger(system_reset_trigger), .port_flag_mode(port_flag_mode),
		.sleep_depth_select(sleep_depth_select), .cycle_done_flag(cycle_done_flag),
		.calibration_select(calibration_select));
	acr_host #(.SCLK_HALF(8)) acr_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
	acr_monitor acr_monitor_inst (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk), .cs_n(link.cs_n),
		.sdi(link.sdi), .sdo(link.sdo));
	// ****************************************************************
	// clock, oscillator and link sniffer
	// ****************************************************************
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// samples both data lines at serial clock rises, runs an 80 ns oscillator, counts ticks
	always @(posedge hclk) begin
		sclk_q <= link.sclk;
		pump_q <= pump_drive_pin;
		osc_div <= osc_div + 2'h1;
		if (osc_en && osc_div == 2'h3) osc_input_clock <= ~osc_input_clock;
		if (link.sclk && !sclk_q && !link.cs_n) begin
			sdi_sh <= {sdi_sh[30:0], link.sdi};
			sdo_sh <= {sdo_sh[30:0], link.sdo};
		end
		if (chop_tick === 1'b1) ticks <= ticks + 1;
		if (pump_drive_pin !== pump_q) toggles <= toggles + 1;
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// one single ahb transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : xfer
	// one link frame through the controller, waits for idle
	task automatic frame(input logic r, input logic [23:0] wd);
		int n;
		n = 0;
		xfer(1'b1, acr_pkg::HOST_WDATA, {8'h00, wd});
		xfer(1'b1, acr_pkg::HOST_CTRL, {30'h0, r, 1'b1});
		do begin
			xfer(1'b0, acr_pkg::HOST_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 1000);
		check("idle", {31'h0, rd[0]}, 32'h0);
		check("command", {24'h0, sdi_sh[31:24]}, r ? 32'h94 : 32'h84);
		if (!r) check("sent word", {8'h0, sdi_sh[23:0]}, {8'h0, wd & ~acr_pkg::CFG_UNUSED});
	endtask : frame
	task automatic rd_setup(input logic [23:0] exp);
		frame(1'b1, 24'h0);
		check("wire word", {8'h0, sdo_sh[23:0]}, {8'h0, exp});
		xfer(1'b0, acr_pkg::HOST_RDATA, 32'h0);
		check("setup", rd, {8'h0, exp});
	endtask : rd_setup
	task automatic run_osc(input int n);
		osc_en <= 1'b1;
		repeat (n) @(posedge osc_input_clock);
		@(posedge hclk);
		osc_en <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask : run_osc
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, osc_input_clock, osc_en, sclk_q, pump_q, osc_div} = '0;
		{ticks, toggles, mismatches, n_checks} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check("reset outs", {8'h0, outs}, 32'h000000);
		rd_setup(24'h000040);
		rd_setup(24'h000000);
		xfer(1'b1, acr_pkg::HOST_IRQ_EN, 32'h3);
		wr_loop: for (int i = 0; i < 8; i++) begin
			w = {4'(i), 1'b0, i[0], 1'b0, i[1], 3'(i), i[2], 3'(i % 6), i[0], 1'b0, 1'b0, i[1], i[2], 1'b0, cal_codes[i]};
			frame(1'b0, w | 24'h0A0048);
			check("outputs", {8'h0, outs}, {8'h0, w});
		end
		check("irq", {31'h0, irq}, 32'h1);
		rd_setup(w);
		xfer(1'b1, acr_pkg::HOST_IRQ_CLR, 32'h3);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, acr_pkg::HOST_IRQ_EN, i < 2 ? 32'h3 : 32'h0);
			xfer(1'b1, acr_pkg::HOST_WDATA, {8'h00, bad[i]});
			xfer(1'b1, acr_pkg::HOST_CTRL, 32'h1);
			xfer(1'b0, acr_pkg::HOST_STATUS, 32'h0);
			check("busy", rd, 32'h0);
			xfer(1'b0, acr_pkg::HOST_IRQ_STAT, 32'h0);
			check("refused", rd, 32'h2);
			check("irq level", {31'h0, irq}, i < 2 ? 32'h1 : 32'h0);
			check("kept", {8'h0, outs}, {8'h0, w});
			xfer(1'b1, acr_pkg::HOST_IRQ_CLR, 32'h3);
		end
		xfer(1'b0, 8'h1C, 32'h0);
		check("unmapped", rd, 32'h0);
		frame(1'b0, 24'hF00080);
		check("reset cycle", {8'h0, outs}, 32'h000080);
		rd_setup(24'h0000C0);
		rd_setup(24'h0000C0);
		frame(1'b0, 24'h000000);
		check("reset off", {31'h0, system_reset_trigger}, 32'h0);
		rd_setup(24'h000040);
		rd_setup(24'h000000);
		frame(1'b0, 24'h04A000);
		ticks <= 0;
		toggles <= 0;
		run_osc(150);
		check("done pin", {31'h0, cycle_done_flag}, 32'h0);
		rd_setup(24'h04A000);
		run_osc(20);
		check("done pin", {31'h0, cycle_done_flag}, 32'h1);
		rd_setup(24'h04A008);
		rd_setup(24'h04A000);
		check("chop ticks", ticks, 32'd170);
		check("pump toggles", toggles, 32'd170);
		// slow chop: one tick per 128 oscillator rises; pump off stays still
		frame(1'b0, 24'h00A100);
		ticks <= 0;
		toggles <= 0;
		run_osc(128);
		check("slow chop", ticks, 32'd1);
		check("pump off", toggles, 32'd0);
		check("pump float", {31'h0, pump_drive_oe}, 32'h0);
		check("okay", {31'h0, hresp}, 32'h0);
		complete_run();
	end
	// watchdog
	initial begin
		#900000;
		mismatches++;
		complete_run();
	end
endmodule : test_adc_configuration_register
